// ===== rtl/mtsc_regs.svh
// Register offsets, field positions, reset values for the timer shared control
`ifndef MTSC_REGS_SVH
`define MTSC_REGS_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define MTSC_RUN_OFS   28'h5ffff00
`define MTSC_SYNC_OFS  28'h5ffff01
`define MTSC_MODE_OFS  28'h5ffff02
`define MTSC_STAT_OFS  28'h5ffff40
`define MTSC_MASK_OFS  28'h5ffff41

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define MTSC_NCH       5
`define MTSC_CH_MSB    4
`define MTSC_FLAG_DIR_BIT 5
`define MTSC_PHASE_BIT    6
`define MTSC_EV_SCLR   0
`define MTSC_EV_WRAP   1
`define MTSC_EV_SPRE   2
`define MTSC_NEV       3

// ------------------------------------------------------------
// Reset and fixed read values
// ------------------------------------------------------------
`define MTSC_CH_RST    5'h00
`define MTSC_EV_RST    3'h0
`define MTSC_RUN_TOP   3'h7
`define MTSC_SYNC_TOP  2'h3
`define MTSC_RD_NONE   8'h00

`endif

// ===== rtl/mtsc_pkg.sv
// Types shared by the timer shared control files
package mtsc_pkg;
   typedef logic [27:0] mtsc_addr_t;
   typedef logic [7:0]  mtsc_byte_t;
   typedef logic [4:0]  mtsc_ch_t;
   typedef logic [2:0]  mtsc_ev_t;
endpackage

// ===== rtl/mtsc_chan.sv
// Per-channel run, preset and clear gating for one timer channel
`timescale 1ns/1ps
module mtsc_chan
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Control bits
   input  wire logic run,
   input  wire logic lockstep,
   // Own sources and shared sync events
   input  wire logic own_clear,
   input  wire logic own_preset,
   input  wire logic any_sync_clear,
   input  wire logic any_sync_preset,
   // To the channel counter
   output logic      advance_q,
   output logic      clear_q,
   output logic      preset_q
);

   logic clear_d;
   logic preset_d;

   // Shared events reach only locked channels; free ones see their own
   assign clear_d  = own_clear | (lockstep & any_sync_clear);
   assign preset_d = own_preset | (lockstep & any_sync_preset);

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         advance_q <= 1'b0;
         clear_q   <= 1'b0;
         preset_q  <= 1'b0;
      end
      else
      begin
         // Stop only withholds advance; count value is untouched
         advance_q <= run;
         clear_q   <= clear_d;
         preset_q  <= preset_d;
      end
   end

endmodule

// ===== rtl/mtsc_top.sv
// Shared control of the five-channel timer: run, lockstep and mode registers
//
// Contract
// - run bit set advances channel counter
// - unlocked channel ignores other channels' preset/clear
// - locked channels share preset and clear
// - mode bit 6 selects channel 2 phase counting
// - mode bit 5 chooses channel 2 wrap flag events
// - mode bits 4..0 select per-channel pulse mode
// - reset clears all control bits
// - unused upper run/sync bits read one (sync bit 7 reads zero; only sync bits 6..5 read one)
// - locked clear follows another locked channel's clear
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "mtsc_regs.svh"
module mtsc_top
(
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               reset,
   // Register port
   input  wire mtsc_pkg::mtsc_addr_t reg_addr,
   input  wire mtsc_pkg::mtsc_byte_t reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output mtsc_pkg::mtsc_byte_t    reg_rdata_q,
   // Events from the channels
   input  wire mtsc_pkg::mtsc_ch_t chan_clear_req,
   input  wire mtsc_pkg::mtsc_ch_t chan_preset_req,
   input  wire logic               ch2_overflow,
   input  wire logic               ch2_underflow,
   // Controls to the channels
   output mtsc_pkg::mtsc_ch_t      chan_advance_q,
   output mtsc_pkg::mtsc_ch_t      chan_clear_q,
   output mtsc_pkg::mtsc_ch_t      chan_preset_q,
   output mtsc_pkg::mtsc_ch_t      lockstep_q,
   output mtsc_pkg::mtsc_ch_t      pulse_mode_q,
   output logic                    phase_count_select_q,
   output logic                    overflow_flag_direction_q,
   output logic                    ch2_wrap_set_q,
   // Interrupt
   output logic                    irq_q
);
   import mtsc_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   mtsc_ch_t run_q;
   mtsc_ch_t run_d;
   mtsc_ch_t sync_d;
   mtsc_ch_t pwm_d;
   logic     phase_sel_d;
   logic     flag_dir_d;
   mtsc_ev_t stat_q;
   mtsc_ev_t stat_d;
   mtsc_ev_t mask_q;
   mtsc_ev_t mask_d;
   mtsc_ev_t events;
   mtsc_byte_t rdata_d;
   logic     wrap_d;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire hit_run  = (reg_addr == `MTSC_RUN_OFS);
   wire hit_sync = (reg_addr == `MTSC_SYNC_OFS);
   wire hit_mode = (reg_addr == `MTSC_MODE_OFS);
   wire hit_stat = (reg_addr == `MTSC_STAT_OFS);
   wire hit_mask = (reg_addr == `MTSC_MASK_OFS);

   wire wr_run  = reg_wr & hit_run;
   wire wr_sync = reg_wr & hit_sync;
   wire wr_mode = reg_wr & hit_mode;
   wire wr_stat = reg_wr & hit_stat;
   wire wr_mask = reg_wr & hit_mask;

   // ------------------------------------------------------------
   // Next values of the control registers
   // ------------------------------------------------------------
   assign run_d  = wr_run  ? reg_wdata[`MTSC_CH_MSB:0] : run_q;
   assign sync_d = wr_sync ? reg_wdata[`MTSC_CH_MSB:0] : lockstep_q;
   assign pwm_d  = wr_mode ? reg_wdata[`MTSC_CH_MSB:0] : pulse_mode_q;
   assign phase_sel_d = wr_mode ? reg_wdata[`MTSC_PHASE_BIT]
                                : phase_count_select_q;
   assign flag_dir_d  = wr_mode ? reg_wdata[`MTSC_FLAG_DIR_BIT]
                                : overflow_flag_direction_q;
   assign mask_d = wr_mask ? reg_wdata[`MTSC_NEV-1:0] : mask_q;

   // ------------------------------------------------------------
   // Lockstep events
   // ------------------------------------------------------------
   // Only locked channels may raise the shared clear or preset
   wire any_sync_clear  = |(chan_clear_req & lockstep_q);
   wire any_sync_preset = |(chan_preset_req & lockstep_q);

   // Underflow counts only while the direction bit is low
   assign wrap_d = ch2_overflow
                 | (ch2_underflow & ~overflow_flag_direction_q);

   // ------------------------------------------------------------
   // Sticky status, write one to clear; a new event wins
   // ------------------------------------------------------------
   assign events[`MTSC_EV_SCLR] = any_sync_clear;
   assign events[`MTSC_EV_WRAP] = wrap_d;
   assign events[`MTSC_EV_SPRE] = any_sync_preset;

   wire [`MTSC_NEV-1:0] stat_clr = wr_stat ? reg_wdata[`MTSC_NEV-1:0]
                                           : `MTSC_EV_RST;
   assign stat_d = (stat_q & ~stat_clr) | events;

   wire irq_d = |(stat_d & mask_d);

   // ------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ------------------------------------------------------------
   // Unused top bits read one in run (7..5) and sync (6..5); the other unused bits read zero
   wire [7:0] rd_run  = {`MTSC_RUN_TOP, run_q};
   wire [7:0] rd_sync = {1'b0, `MTSC_SYNC_TOP, lockstep_q};
   wire [7:0] rd_mode = {1'b0, phase_count_select_q,
                         overflow_flag_direction_q, pulse_mode_q};
   wire [7:0] rd_stat = {5'h00, stat_q};
   wire [7:0] rd_mask = {5'h00, mask_q};

   assign rdata_d = !reg_rd  ? `MTSC_RD_NONE :
                    hit_run  ? rd_run  :
                    hit_sync ? rd_sync :
                    hit_mode ? rd_mode :
                    hit_stat ? rd_stat :
                    hit_mask ? rd_mask : `MTSC_RD_NONE;

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         run_q                     <= `MTSC_CH_RST;
         lockstep_q                <= `MTSC_CH_RST;
         pulse_mode_q              <= `MTSC_CH_RST;
         phase_count_select_q      <= 1'b0;
         overflow_flag_direction_q <= 1'b0;
         stat_q                    <= `MTSC_EV_RST;
         mask_q                    <= `MTSC_EV_RST;
         irq_q                     <= 1'b0;
         ch2_wrap_set_q            <= 1'b0;
         reg_rdata_q               <= `MTSC_RD_NONE;
      end
      else
      begin
         run_q                     <= run_d;
         lockstep_q                <= sync_d;
         pulse_mode_q              <= pwm_d;
         phase_count_select_q      <= phase_sel_d;
         overflow_flag_direction_q <= flag_dir_d;
         stat_q                    <= stat_d;
         mask_q                    <= mask_d;
         irq_q                     <= irq_d;
         ch2_wrap_set_q            <= wrap_d;
         reg_rdata_q               <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // Channel gating
   // ------------------------------------------------------------
   generate
      for (genvar i = 0; i < `MTSC_NCH; i++)
      begin : g_ch
         mtsc_chan u_chan
         (
            .sys_clk         (sys_clk),
            .reset           (reset),
            .run             (run_q[i]),
            .lockstep        (lockstep_q[i]),
            .own_clear       (chan_clear_req[i]),
            .own_preset      (chan_preset_req[i]),
            .any_sync_clear  (any_sync_clear),
            .any_sync_preset (any_sync_preset),
            .advance_q       (chan_advance_q[i]),
            .clear_q         (chan_clear_q[i]),
            .preset_q        (chan_preset_q[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   property p_run_write;
      mtsc_ch_t v;
      (wr_run, v = reg_wdata[`MTSC_CH_MSB:0]) ##2 !$past(wr_run)
         |-> chan_advance_q == v;
   endproperty
   a_run_write : assert property (p_run_write)
      else $error("advance does not follow run write");

   property p_free_isolated;
      ##1 !$past(reset) |-> (chan_clear_q & ~$past(lockstep_q))
                   == $past(chan_clear_req & ~lockstep_q);
   endproperty
   a_free_isolated : assert property (p_free_isolated)
      else $error("free channel saw a foreign clear");

   property p_sync_preset;
      any_sync_preset |=>
         (chan_preset_q & $past(lockstep_q)) == $past(lockstep_q);
   endproperty
   a_sync_preset : assert property (p_sync_preset)
      else $error("locked channel missed shared preset");

   property p_phase_write;
      logic b;
      (wr_mode, b = reg_wdata[`MTSC_PHASE_BIT]) |=> phase_count_select_q == b;
   endproperty
   a_phase_write : assert property (p_phase_write)
      else $error("phase select not taken from write");

   property p_wrap_dir;
      ch2_underflow && !ch2_overflow |=>
         ch2_wrap_set_q == !$past(overflow_flag_direction_q);
   endproperty
   a_wrap_dir : assert property (p_wrap_dir)
      else $error("underflow wrap flag ignores direction");

   property p_wrap_ovf;
      ch2_overflow |=> ch2_wrap_set_q;
   endproperty
   a_wrap_ovf : assert property (p_wrap_ovf)
      else $error("overflow did not set wrap flag");

   property p_pwm_write;
      mtsc_ch_t v;
      (wr_mode, v = reg_wdata[`MTSC_CH_MSB:0]) |=> pulse_mode_q == v;
   endproperty
   a_pwm_write : assert property (p_pwm_write)
      else $error("pulse mode bits not taken from write");

   property p_reset_state;
      @(posedge sys_clk) disable iff (1'b0) reset |=> run_q == `MTSC_CH_RST
         && lockstep_q == `MTSC_CH_RST && pulse_mode_q == `MTSC_CH_RST
         && !phase_count_select_q && !overflow_flag_direction_q;
   endproperty
   a_reset_state : assert property (p_reset_state)
      else $error("control bits not cleared by reset");

   property p_read_top;
      reg_rd && hit_run |=> reg_rdata_q[7:5] == 3'h7;
   endproperty
   a_read_top : assert property (p_read_top)
      else $error("unused run bits not read as one");

   property p_sync_read_top;
      reg_rd && hit_sync |=> reg_rdata_q[6:5] == 2'h3;
   endproperty
   a_sync_read_top : assert property (p_sync_read_top)
      else $error("unused sync bits not read as one");

   property p_sync_clear;
      any_sync_clear |=>
         (chan_clear_q & $past(lockstep_q)) == $past(lockstep_q);
   endproperty
   a_sync_clear : assert property (p_sync_clear)
      else $error("locked channel missed shared clear");

   property p_stop_no_clear;
      wr_run && !any_sync_clear && chan_clear_req == `MTSC_CH_RST
         |=> chan_clear_q == `MTSC_CH_RST;
   endproperty
   a_stop_no_clear : assert property (p_stop_no_clear)
      else $error("run write caused a counter clear");

   property p_irq_level;
      ##1 !$past(reset) |-> irq_q == |($past(stat_d) & $past(mask_d));
   endproperty
   a_irq_level : assert property (p_irq_level)
      else $error("interrupt level disagrees with status");

   property p_set_wins;
      !reset && events != `MTSC_EV_RST |=> (stat_q & $past(events)) == $past(events);
   endproperty
   a_set_wins : assert property (p_set_wins)
      else $error("status event lost to a clear");

   property p_stat_clear;
      !reset && wr_stat |=>
         (stat_q & $past(reg_wdata[`MTSC_NEV-1:0] & ~events)) == `MTSC_EV_RST;
   endproperty
   a_stat_clear : assert property (p_stat_clear)
      else $error("status bit survived write one clear");

   property p_rdata_idle;
      !reg_rd |=> reg_rdata_q == `MTSC_RD_NONE;
   endproperty
   a_rdata_idle : assert property (p_rdata_idle)
      else $error("read data outside the read cycle");

   property p_unmapped_read;
      reg_rd && !(hit_run || hit_sync || hit_mode || hit_stat || hit_mask)
         |=> reg_rdata_q == `MTSC_RD_NONE;
   endproperty
   a_unmapped_read : assert property (p_unmapped_read)
      else $error("unmapped read returned data");

   property p_sync_write;
      mtsc_ch_t v;
      (!reset && wr_sync, v = reg_wdata[`MTSC_CH_MSB:0]) |=> lockstep_q == v;
   endproperty
   a_sync_write : assert property (p_sync_write)
      else $error("lockstep bits not taken from write");

   property p_mask_write;
      mtsc_ev_t m;
      (!reset && wr_mask, m = reg_wdata[`MTSC_NEV-1:0]) |=> mask_q == m;
   endproperty
   a_mask_write : assert property (p_mask_write)
      else $error("mask bits not taken from write");

   property p_flag_dir_write;
      logic b;
      (!reset && wr_mode, b = reg_wdata[`MTSC_FLAG_DIR_BIT]) |=>
         overflow_flag_direction_q == b;
   endproperty
   a_flag_dir_write : assert property (p_flag_dir_write)
      else $error("flag direction not taken from write");

   property p_run_hold;
      !reset && !wr_run |=> run_q == $past(run_q);
   endproperty
   a_run_hold : assert property (p_run_hold)
      else $error("run bits changed without a write");

   property p_irq_now;
      irq_q == |(stat_q & mask_q);
   endproperty
   a_irq_now : assert property (p_irq_now)
      else $error("interrupt level differs from masked status");

   c_sync_clear  : cover property (any_sync_clear ##1 irq_q);
   c_wrap_under  : cover property (ch2_underflow ##1 ch2_wrap_set_q);
   c_run_stop    : cover property (chan_advance_q[0] ##[1:8] !chan_advance_q[0]);
   c_stat_clear  : cover property (wr_stat ##1 stat_q == `MTSC_EV_RST);
   c_set_wins    : cover property (wr_stat && reg_wdata[`MTSC_EV_WRAP] && wrap_d
                                   ##1 stat_q[`MTSC_EV_WRAP]);

endmodule

// ===== verif/tb_multi_channel_timer_shared_control.sv
// Self-checking bench for the timer shared control block
`timescale 1ns/1ps
`include "mtsc_regs.svh"
module tb_multi_channel_timer_shared_control;
   import mtsc_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic       sys_clk;
   logic       reset;
   mtsc_addr_t reg_addr;
   mtsc_byte_t reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   mtsc_byte_t reg_rdata_q;
   mtsc_ch_t   chan_clear_req;
   mtsc_ch_t   chan_preset_req;
   logic       ch2_overflow;
   logic       ch2_underflow;
   mtsc_ch_t   chan_advance_q;
   mtsc_ch_t   chan_clear_q;
   mtsc_ch_t   chan_preset_q;
   mtsc_ch_t   lockstep_q;
   mtsc_ch_t   pulse_mode_q;
   logic       phase_count_select_q;
   logic       overflow_flag_direction_q;
   logic       ch2_wrap_set_q;
   logic       irq_q;
   int         failures;
   int         compares;

   mtsc_top dut
   (
      .sys_clk                   (sys_clk),
      .reset                     (reset),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_wr                    (reg_wr),
      .reg_rd                    (reg_rd),
      .reg_rdata_q               (reg_rdata_q),
      .chan_clear_req            (chan_clear_req),
      .chan_preset_req           (chan_preset_req),
      .ch2_overflow              (ch2_overflow),
      .ch2_underflow             (ch2_underflow),
      .chan_advance_q            (chan_advance_q),
      .chan_clear_q              (chan_clear_q),
      .chan_preset_q             (chan_preset_q),
      .lockstep_q                (lockstep_q),
      .pulse_mode_q              (pulse_mode_q),
      .phase_count_select_q      (phase_count_select_q),
      .overflow_flag_direction_q (overflow_flag_direction_q),
      .ch2_wrap_set_q            (ch2_wrap_set_q),
      .irq_q                     (irq_q)
   );

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wr(input mtsc_addr_t a, input mtsc_byte_t d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task rdc(input mtsc_addr_t a, input string what, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, reg_rdata_q, exp);
   endtask

   task settle;
      @(posedge sys_clk);
      #1;
   endtask

   // One cycle of channel events; outputs looked at one edge later
   task ev(input mtsc_ch_t c, input mtsc_ch_t p, input logic ov, input logic un);
      @(posedge sys_clk);
      chan_clear_req  <= c;
      chan_preset_req <= p;
      ch2_overflow    <= ov;
      ch2_underflow   <= un;
      @(posedge sys_clk);
      chan_clear_req  <= 5'h00;
      chan_preset_req <= 5'h00;
      ch2_overflow    <= 1'b0;
      ch2_underflow   <= 1'b0;
      #1;
   endtask

   task results;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      $display("wrong value watchdog expected done seen hang");
      results;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      failures = 0;
      compares = 0;
      reset = 1'b1;
      reg_addr = 28'h0000000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      chan_clear_req = 5'h00;
      chan_preset_req = 5'h00;
      ch2_overflow = 1'b0;
      ch2_underflow = 1'b0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      chk("advance", {3'h0, chan_advance_q}, 8'h00);
      chk("pulse", {3'h0, pulse_mode_q}, 8'h00);
      chk("flags", {6'h00, phase_count_select_q, overflow_flag_direction_q}, 8'h00);
      rdc(`MTSC_RUN_OFS, "run", 8'he0);
      settle;
      chk("rdata idle", reg_rdata_q, 8'h00);
      rdc(`MTSC_SYNC_OFS, "sync", 8'h60);
      rdc(`MTSC_MODE_OFS, "mode", 8'h00);
      rdc(28'h5ffff03, "unmapped", 8'h00);
      // Run bits gate advance only; stopping issues no clear
      wr(`MTSC_RUN_OFS, 8'h15);
      settle;
      chk("advance", {3'h0, chan_advance_q}, 8'h15);
      rdc(`MTSC_RUN_OFS, "run", 8'hf5);
      wr(`MTSC_RUN_OFS, 8'h04);
      settle;
      chk("advance", {3'h0, chan_advance_q}, 8'h04);
      chk("clear", {3'h0, chan_clear_q}, 8'h00);
      // Walk each mode bit alone
      for (int i = 0; i < 7; i++)
      begin
         wr(`MTSC_MODE_OFS, 8'h01 << i);
         settle;
         chk("pulse", {3'h0, pulse_mode_q}, (i < 5) ? (8'h01 << i) : 8'h00);
         chk("phase", {7'h00, phase_count_select_q}, (i == 6) ? 8'h01 : 8'h00);
         chk("flagdir", {7'h00, overflow_flag_direction_q}, (i == 5) ? 8'h01 : 8'h00);
         rdc(`MTSC_MODE_OFS, "mode", 8'h01 << i);
      end
      for (int f = 0; f < 2; f++)
      begin
         wr(`MTSC_MODE_OFS, (f == 1) ? 8'h20 : 8'h00);
         ev(5'h00, 5'h00, 1'b1, 1'b0);
         chk("wrap ovf", {7'h00, ch2_wrap_set_q}, 8'h01);
         ev(5'h00, 5'h00, 1'b0, 1'b1);
         chk("wrap unf", {7'h00, ch2_wrap_set_q}, (f == 0) ? 8'h01 : 8'h00);
      end
      // Independent channels see only their own sources; locked channels 0 and 1 then share clear and preset
      ev(5'h01, 5'h00, 1'b0, 1'b0);
      chk("clear", {3'h0, chan_clear_q}, 8'h01);
      ev(5'h00, 5'h08, 1'b0, 1'b0);
      chk("preset", {3'h0, chan_preset_q}, 8'h08);
      wr(`MTSC_SYNC_OFS, 8'h03);
      settle;
      chk("lockstep", {3'h0, lockstep_q}, 8'h03);
      rdc(`MTSC_SYNC_OFS, "sync", 8'h63);
      ev(5'h01, 5'h00, 1'b0, 1'b0);
      chk("clear", {3'h0, chan_clear_q}, 8'h03);
      ev(5'h04, 5'h00, 1'b0, 1'b0);
      chk("clear", {3'h0, chan_clear_q}, 8'h04);
      ev(5'h05, 5'h02, 1'b0, 1'b0);
      chk("clear", {3'h0, chan_clear_q}, 8'h07);
      chk("preset", {3'h0, chan_preset_q}, 8'h03);
      // Interrupt: sticky status, mask, write one to clear
      wr(`MTSC_STAT_OFS, 8'h07);
      rdc(`MTSC_STAT_OFS, "status", 8'h00);
      ev(5'h02, 5'h01, 1'b1, 1'b0);
      chk("irq masked", {7'h00, irq_q}, 8'h00);
      rdc(`MTSC_STAT_OFS, "status", 8'h07);
      wr(`MTSC_MASK_OFS, 8'h02);
      settle;
      chk("irq", {7'h00, irq_q}, 8'h01);
      rdc(`MTSC_MASK_OFS, "mask", 8'h02);
      wr(`MTSC_STAT_OFS, 8'h02);
      settle;
      chk("irq cleared", {7'h00, irq_q}, 8'h00);
      rdc(`MTSC_STAT_OFS, "status", 8'h05);
      // A wrap event in the cycle of its own clear keeps the bit set
      @(posedge sys_clk);
      reg_wr       <= 1'b1;
      reg_addr     <= `MTSC_STAT_OFS;
      reg_wdata    <= 8'h02;
      ch2_overflow <= 1'b1;
      @(posedge sys_clk);
      reg_wr       <= 1'b0;
      ch2_overflow <= 1'b0;
      settle;
      chk("irq set wins", {7'h00, irq_q}, 8'h01);
      rdc(`MTSC_STAT_OFS, "status", 8'h07);
      // Second reset in mid-run
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      #1;
      chk("advance", {3'h0, chan_advance_q}, 8'h00);
      chk("lockstep", {3'h0, lockstep_q}, 8'h00);
      rdc(`MTSC_SYNC_OFS, "sync", 8'h60);
      rdc(`MTSC_MODE_OFS, "mode", 8'h00);
      rdc(`MTSC_RUN_OFS, "run", 8'he0);
      results;
   end
endmodule
